/* obc_defines.vh */
/*
  Constants for the option byte configuration loader: option byte
  addresses, field positions, register addresses and reset values.
  Assumes a byte-wide flash read port and a byte-wide memory bus.
*/
// Function
// - bit 0 of byte 0081H picks power-on-clear mode: 0 single, 1 dual threshold.
// - mode bit comes only from programmer writes; self-programming forces single threshold.
// - boot swap copies 1081H option byte into 0081H.
// - bits 1:0 of 0084H: 00 off, 01 prohibited, 10 keep, 11 erase on failure.
// - option bytes are read and applied during reset processing.
// - memory size register at FFF0H, 8 bits, resets to CFH.
// - RAM field 110 selects 1024 bytes, ROM field 0100 selects 16 KB.
// - expansion RAM size register at FFF4H, 8 bits, resets to 0CH.
// - expansion field 01000 selects 2048 bytes; software writes 08H.
// - clocked serial programming: programmer drives clock and data; internal fast oscillator only.
// - async serial programming: crystal or external clock only.
`ifndef OBC_DEFINES_VH
`define OBC_DEFINES_VH
`define OBC_ADDR_POC       16'h0081
`define OBC_ADDR_DBG       16'h0084
`define OBC_SWAP_OFFSET    16'h1000
`define OBC_POC_BIT        0
`define OBC_DBG_HI         1
`define OBC_DBG_LO         0
`define OBC_ADDR_MSS       16'hFFF0
`define OBC_ADDR_XRS       16'hFFF4
`define OBC_MSS_RESET      8'hCF
`define OBC_XRS_RESET      8'h0C
`define OBC_MSS_MASK       8'hEF
`define OBC_XRS_MASK       8'h1F
`define OBC_RAM_HI         7
`define OBC_RAM_LO         5
`define OBC_ROM_HI         3
`define OBC_ROM_LO         0
`define OBC_RAM_1K         3'h6
`define OBC_ROM_16K        4'h4
`define OBC_XRAM_2K        5'h08
`define OBC_DBG_PROHIB     2'h1
`define OBC_DBG_ERASE      2'h3
`endif

/* obc_size_decode.v */
/*
  Decodes the memory size and expansion RAM size registers into
  capacity selects and a prohibited-code flag.
  Assumes registered inputs; outputs are registered in the parent.
*/
`default_nettype none
`include "obc_defines.vh"
module obc_size_decode (
  // register values
  input  wire [7:0] memSizeSel,
  input  wire [7:0] xramSizeSel,
  // decoded capacities
  output wire       ram1k,
  output wire       rom16k,
  output wire       xram2k,
  output wire       sizeProhibited
);
  assign ram1k  = (memSizeSel[`OBC_RAM_HI:`OBC_RAM_LO] == `OBC_RAM_1K);
  assign rom16k = (memSizeSel[`OBC_ROM_HI:`OBC_ROM_LO] == `OBC_ROM_16K);
  assign xram2k = (xramSizeSel[4:0] == `OBC_XRAM_2K);
  assign sizeProhibited = ~(ram1k & rom16k & xram2k);
endmodule
`default_nettype wire

/* obc_option_loader.v */
/*
  Option byte loader and memory size registers. During reset processing
  it reads the option bytes from flash (swap copy when boot swap is
  active), latches the fields, then releases the core.
  Assumes a flash read port with one-cycle read latency and a byte bus.
  Limitations: the flash must answer within one cycle of an address
  change; size register writes are ignored until loading is done;
  self-programming always yields the single-threshold clear mode.
  Trade-off: three fixed load cycles rather than a handshake with the
  flash, which keeps reset processing short and its length known.
*/
`default_nettype none
`include "obc_defines.vh"
module obc_option_loader (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        clkEn,
  // reset processing context
  input  wire        bootSwap,
  input  wire        selfProgramming,
  input  wire        programmerMode,
  input  wire        serialChannelIsClocked,
  // flash read port
  output reg  [15:0] flashAddr_q,
  output reg         flashRead_q,
  input  wire [7:0]  flashData,
  // byte register bus
  input  wire [15:0] busAddr,
  input  wire        busWrite,
  input  wire        busRead,
  input  wire [7:0]  busWdata,
  output reg  [7:0]  busRdata_q,
  // configuration outputs
  output reg         powerOnClearLevelSelect_q,
  output reg         debugEnableHigh_q,
  output reg         debugEnableLow_q,
  output reg         debugSettingProhibited_q,
  output reg         loadDone_q,
  output reg         useInternalFastOsc_q,
  output reg         ram1k_q,
  output reg         rom16k_q,
  output reg         xram2k_q,
  output reg         sizeProhibited_q
);
  // one-hot load sequence states
  localparam [3:0] ST_POC  = 4'h1;
  localparam [3:0] ST_DBG  = 4'h2;
  localparam [3:0] ST_LAST = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // load sequence
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;

  // flash read port next values
  reg  [15:0] flashAddr_d;
  reg         flashRead_d;

  // option field next values
  reg         pocLevel_d;
  reg         dbgHigh_d;
  reg         dbgLow_d;
  reg         dbgProhib_d;
  reg         loadDone_d;
  reg         fastOsc_d;

  // size registers and read data
  reg  [7:0]  memSizeSel_q;
  reg  [7:0]  memSizeSel_d;
  reg  [7:0]  xramSizeSel_q;
  reg  [7:0]  xramSizeSel_d;
  reg  [7:0]  busRdata_d;

  // bus decode
  wire [15:0] base;
  wire        mssHit;
  wire        xrsHit;
  wire        mssWrEn;
  wire        xrsWrEn;

  // decoded capacities
  wire        ram1k;
  wire        rom16k;
  wire        xram2k;
  wire        sizeProhibited;
  wire        unusedProg;

  // swap copy stands at the upper bank
  assign base = bootSwap ? `OBC_SWAP_OFFSET : 16'h0000;

  // one read issued in each of ST_POC and ST_DBG; its byte is taken one state later
  always @* begin
    state_d     = state_q;
    flashAddr_d = flashAddr_q;
    flashRead_d = flashRead_q;
    fastOsc_d   = useInternalFastOsc_q;
    pocLevel_d  = powerOnClearLevelSelect_q;
    dbgHigh_d   = debugEnableHigh_q;
    dbgLow_d    = debugEnableLow_q;
    dbgProhib_d = debugSettingProhibited_q;
    loadDone_d  = loadDone_q;
    case (state_q)
      ST_POC: begin
        state_d     = ST_DBG;
        flashAddr_d = base + `OBC_ADDR_POC;
        flashRead_d = 1'b1;
        fastOsc_d   = serialChannelIsClocked;
      end
      ST_DBG: begin
        state_d     = ST_LAST;
        flashAddr_d = base + `OBC_ADDR_DBG;
        // self-programming cannot raise the threshold mode
        pocLevel_d  = flashData[`OBC_POC_BIT] & ~selfProgramming;
      end
      ST_LAST: begin
        state_d     = ST_DONE;
        flashRead_d = 1'b0;
        dbgHigh_d   = flashData[`OBC_DBG_HI];
        dbgLow_d    = flashData[`OBC_DBG_LO];
        dbgProhib_d = (flashData[`OBC_DBG_HI:`OBC_DBG_LO] == `OBC_DBG_PROHIB);
        loadDone_d  = 1'b1;
      end
      ST_DONE: begin
        // stays here until the next reset
        flashRead_d = 1'b0;
      end
      default: begin
        // an illegal code restarts the load
        state_d     = ST_POC;
        flashRead_d = 1'b0;
      end
    endcase
  end

  // option fields load once per reset, then freeze
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q                   <= ST_POC;
      flashAddr_q               <= 16'h0000;
      flashRead_q               <= 1'b0;
      powerOnClearLevelSelect_q <= 1'b0;
      debugEnableHigh_q         <= 1'b0;
      debugEnableLow_q          <= 1'b0;
      debugSettingProhibited_q  <= 1'b0;
      loadDone_q                <= 1'b0;
      useInternalFastOsc_q      <= 1'b0;
    end else if (clkEn) begin
      state_q                   <= state_d;
      flashAddr_q               <= flashAddr_d;
      flashRead_q               <= flashRead_d;
      powerOnClearLevelSelect_q <= pocLevel_d;
      debugEnableHigh_q         <= dbgHigh_d;
      debugEnableLow_q          <= dbgLow_d;
      debugSettingProhibited_q  <= dbgProhib_d;
      loadDone_q                <= loadDone_d;
      useInternalFastOsc_q      <= fastOsc_d;
    end
  end

  assign mssHit  = (busAddr == `OBC_ADDR_MSS);
  assign xrsHit  = (busAddr == `OBC_ADDR_XRS);
  // writes before load completes are dropped: the core is not running yet
  assign mssWrEn = busWrite & loadDone_q & mssHit;
  assign xrsWrEn = busWrite & loadDone_q & xrsHit;

  // reserved bits always read back as zero
  always @* begin
    memSizeSel_d  = memSizeSel_q;
    xramSizeSel_d = xramSizeSel_q;
    if (mssWrEn) begin
      memSizeSel_d = busWdata & `OBC_MSS_MASK;
    end
    if (xrsWrEn) begin
      xramSizeSel_d = busWdata & `OBC_XRS_MASK;
    end
  end

  // unmapped addresses read as zero
  always @* begin
    busRdata_d = 8'h00;
    if (busRead && mssHit) begin
      busRdata_d = memSizeSel_q;
    end else if (busRead && xrsHit) begin
      busRdata_d = xramSizeSel_q;
    end
  end

  // decodes lag the register by one cycle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      memSizeSel_q     <= `OBC_MSS_RESET;
      xramSizeSel_q    <= `OBC_XRS_RESET;
      busRdata_q       <= 8'h00;
      ram1k_q          <= 1'b0;
      rom16k_q         <= 1'b0;
      xram2k_q         <= 1'b0;
      sizeProhibited_q <= 1'b1;
    end else if (clkEn) begin
      memSizeSel_q     <= memSizeSel_d;
      xramSizeSel_q    <= xramSizeSel_d;
      busRdata_q       <= busRdata_d;
      ram1k_q          <= ram1k;
      rom16k_q         <= rom16k;
      xram2k_q         <= xram2k;
      sizeProhibited_q <= sizeProhibited;
    end
  end

  obc_size_decode uDecode (
    .memSizeSel     (memSizeSel_q),
    .xramSizeSel    (xramSizeSel_q),
    .ram1k          (ram1k),
    .rom16k         (rom16k),
    .xram2k         (xram2k),
    .sizeProhibited (sizeProhibited)
  );

  // programmerMode is carried for the flash controller; nothing here differs
  assign unusedProg = programmerMode;
endmodule
`default_nettype wire

/* obc_flash_model.sv */
/* Flash model holding the option bytes and their swap copies.
   Assumes the loader reads combinationally on flashAddr_q. */
`default_nettype none
module obc_flash_model (
  // option image {1084H, 1081H, 0084H, 0081H}
  input  wire logic [31:0] optImage,
  // flash read port
  input  wire logic [15:0] flashAddr_q,
  input  wire logic        flashRead_q,
  output logic      [7:0]  flashData
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    case (flashAddr_q)
      16'h0081: flashData = optImage[7:0];
      16'h0084: flashData = optImage[15:8];
      16'h1081: flashData = optImage[23:16];
      16'h1084: flashData = optImage[31:24];
      16'h0082, 16'h0083, 16'h1082, 16'h1083: flashData = 8'h00;
      default: flashData = 8'hA5;
    endcase
    // no stale byte while not reading
    if (!flashRead_q) flashData = ~flashData;
  end
endmodule
`default_nettype wire

/* obc_option_loader_asserts.sv */
/* Port checker for the option loader.
   Bound to obc_option_loader; one clock domain. */
`default_nettype none
module obc_option_loader_asserts (
  // clock, reset, context
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        clkEn,
  input wire logic        bootSwap,
  input wire logic        selfProgramming,
  input wire logic        serialChannelIsClocked,
  // flash and bus
  input wire logic [15:0] flashAddr_q,
  input wire logic        flashRead_q,
  input wire logic [7:0]  flashData,
  input wire logic [15:0] busAddr,
  input wire logic        busWrite,
  input wire logic [7:0]  busWdata,
  // configuration
  input wire logic        powerOnClearLevelSelect_q,
  input wire logic        debugEnableHigh_q,
  input wire logic        debugEnableLow_q,
  input wire logic        debugSettingProhibited_q,
  input wire logic        loadDone_q,
  input wire logic        useInternalFastOsc_q,
  input wire logic        ram1k_q,
  input wire logic        rom16k_q,
  input wire logic        xram2k_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bootCnt_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) bootCnt_q <= 2'h0;
    else if (clkEn && bootCnt_q != 2'h3) bootCnt_q <= bootCnt_q + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_firstRead;
    bootCnt_q == 2'h1 |-> flashRead_q && flashAddr_q == (bootSwap ? 16'h1081 : 16'h0081);
  endproperty
  a_firstRead: assert property (p_firstRead) else $error("first option read wrong");
  property p_loadTime;
    loadDone_q == (bootCnt_q == 2'h3);
  endproperty
  a_loadTime: assert property (p_loadTime) else $error("load done at wrong cycle");
  property p_pocLoad;
    logic d;
    (bootCnt_q == 2'h1, d = flashData[0]) |=> powerOnClearLevelSelect_q == (d && !selfProgramming);
  endproperty
  a_pocLoad: assert property (p_pocLoad) else $error("clear level wrong");
  property p_dbgLoad;
    logic [1:0] d;
    (bootCnt_q == 2'h2, d = flashData[1:0]) |=> {debugEnableHigh_q, debugEnableLow_q} == d;
  endproperty
  a_dbgLoad: assert property (p_dbgLoad) else $error("debug field wrong");
  property p_prohib;
    loadDone_q |-> debugSettingProhibited_q == ({debugEnableHigh_q, debugEnableLow_q} == 2'h1);
  endproperty
  a_prohib: assert property (p_prohib) else $error("prohibited flag wrong");
  property p_hold;
    loadDone_q |=> $stable({powerOnClearLevelSelect_q, debugEnableHigh_q, debugEnableLow_q});
  endproperty
  a_hold: assert property (p_hold) else $error("option field moved");
  property p_osc;
    $rose(loadDone_q) |-> useInternalFastOsc_q == serialChannelIsClocked;
  endproperty
  a_osc: assert property (p_osc) else $error("clock source wrong");
  property p_memSize;
    logic [7:0] d;
    (clkEn && loadDone_q && busWrite && busAddr == 16'hFFF0, d = busWdata)
      |-> ##2 ram1k_q == (d[7:5] == 3'h6) && rom16k_q == (d[3:0] == 4'h4);
  endproperty
  a_memSize: assert property (p_memSize) else $error("size decode wrong");
  property p_xram;
    logic [7:0] d;
    (clkEn && loadDone_q && busWrite && busAddr == 16'hFFF4, d = busWdata) |-> ##2 xram2k_q == (d[4:0] == 5'h08);
  endproperty
  a_xram: assert property (p_xram) else $error("expansion decode wrong");
endmodule
bind obc_option_loader obc_option_loader_asserts obc_option_loader_asserts_inst (.*);
`default_nettype wire

/* obc_option_loader_test.sv */
/* Testbench for the option loader with a flash model.
   Assumes the loader contract: load done three edges after reset. */
`default_nettype none
module obc_option_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, reset_n, clkEn, bootSwap, selfProgramming, programmerMode, serialChannelIsClocked;
  logic        busWrite, busRead, flashRead_q, powerOnClearLevelSelect_q, debugEnableHigh_q, debugEnableLow_q;
  logic        debugSettingProhibited_q, loadDone_q, useInternalFastOsc_q, ram1k_q, rom16k_q, xram2k_q;
  logic        sizeProhibited_q;
  logic [15:0] busAddr, flashAddr_q;
  logic [7:0]  busWdata, busRdata_q, flashData;
  logic [31:0] optImage;
  int          mismatches, n_checks, cyc;
  obc_option_loader obc_option_loader_inst (.*);
  obc_flash_model obc_flash_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge core_clk);
    busWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge core_clk);
    busRead <= 1'b0;
    #1 chk(busRdata_q, exp);
  endtask
  // odd i boots from the swap copy, which differs from the base copy
  task automatic boot(input int i);
    @(posedge core_clk);
    reset_n <= 1'b0;
    bootSwap <= i[0];
    selfProgramming <= (i == 2);
    serialChannelIsClocked <= i[1];
    optImage <= i[0] ? {i[7:0], 8'h01, 8'h00, 8'h00} : {8'h00, 8'h00, i[7:0], 8'h01};
    busAddr <= 16'hFFF0;
    busWdata <= 8'h00;
    busWrite <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    busWrite <= 1'b0;
    @(posedge core_clk);
    #1 chk(loadDone_q, 8'h01);
  endtask
  initial begin
    {reset_n, bootSwap, selfProgramming, programmerMode, serialChannelIsClocked, busWrite, busRead} = '0;
    clkEn = 1'b1;
    busAddr = 16'h0000;
    busWdata = 8'h00;
    optImage = 32'h0;
    for (int i = 0; i < 4; i++) begin
      boot(i);
      chk(powerOnClearLevelSelect_q, i != 2);
      chk({debugEnableHigh_q, debugEnableLow_q}, i[1:0]);
      chk(debugSettingProhibited_q, i == 1);
      chk(useInternalFastOsc_q, i[1]);
      rd(16'hFFF0, 8'hCF);
      rd(16'hFFF4, 8'h0C);
      wr(16'hFFF0, 8'hC4);
      wr(16'hFFF4, 8'h08);
      rd(16'hFFF0, 8'hC4);
      rd(16'hFFF4, 8'h08);
      chk({ram1k_q, rom16k_q, xram2k_q, sizeProhibited_q}, 8'h0E);
      wr(16'hFFF0, 8'hFF);
      rd(16'hFFF0, 8'hEF);
      rd(16'h0081, 8'h00);
      chk({ram1k_q, rom16k_q, sizeProhibited_q}, 8'h01);
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule
`default_nettype wire
